// File: stack_limit_check.sv
// Software stack pointer, limit register and stack error detection.
// Assumes an AXI4-Lite master on aclk; one write and one read in flight at most.
`timescale 1ns/1ps
`include "stack_check_cfg.svh"

module stack_limit_check
  import stack_check_pkg::*;
#(
  parameter int DEPTH_WORDS = 64
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  localparam int AW = $clog2(DEPTH_WORDS);

  logic [15:0]      stack_pointer_register_reg;
  logic [15:0]      stack_limit_register_reg;
  logic [15:0]      operand_reg;
  logic [15:0]      last_addr_reg;
  logic [15:0]      read_data_reg;
  logic [2:0]       status_reg;
  logic [2:0]       mask_reg;
  logic [15:0]      stack_mem [DEPTH_WORDS];
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic             wr_fire;
  logic             wr_ok;
  stack_op_type     op_now;
  stack_access_type access_now;
  stack_events_type ev;
  logic [15:0]      push_word;
  logic [15:0]      effective_address;
  logic             ea_valid;

  // Write address and data are caught independently, in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid && !wr_fire;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid && !wr_fire;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Known write offsets; anything else is answered with SLVERR
  always_comb begin
    if (aw_addr_reg == `OFS_STACK_LIMIT || aw_addr_reg == `OFS_STACK_POINTER) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg == `OFS_STATUS || aw_addr_reg == `OFS_MASK) begin
      wr_ok = 1'b1;
    end else if (aw_addr_reg == `OFS_OP || aw_addr_reg == `OFS_OPERAND) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // An operation is launched by a low-lane write to the operation register
  always_comb begin
    op_now = OP_NONE;
    if (wr_fire && aw_addr_reg == `OFS_OP && w_strb_reg[0]) begin
      op_now = stack_op_type'(w_data_reg[2:0]);
    end
  end

  // Call pushes clear the top bit; exception pushes carry the three status bits in bits 14:12
  always_comb begin
    push_word = operand_reg;
    if (op_now == OP_PUSH_CALL_PC) begin
      push_word = {1'b0, operand_reg[14:0]};
    end else if (op_now == OP_PUSH_EXC_PC) begin
      push_word = {1'b0, status_reg, operand_reg[11:0]};
    end
  end

  // Effective address through the stack pointer: post-increment push, pre-decrement pop
  always_comb begin
    ea_valid          = 1'b1;
    effective_address = stack_pointer_register_reg;
    case (op_now)
      OP_PUSH_WORD, OP_PUSH_CALL_PC, OP_PUSH_EXC_PC:
        effective_address = stack_pointer_register_reg;
      OP_POP_WORD:   effective_address = stack_pointer_register_reg - 16'h0002;
      OP_READ_AT_SP: effective_address = stack_pointer_register_reg;
      default:       ea_valid = 1'b0;
    endcase
    access_now.address = effective_address;
    access_now.is_push = (op_now == OP_PUSH_WORD) || (op_now == OP_PUSH_CALL_PC)
                         || (op_now == OP_PUSH_EXC_PC);
  end

  // Limit compare; a push exactly at the limit is still allowed
  always_comb begin
    ev.overflow  = ea_valid && access_now.is_push
                   && (access_now.address > stack_limit_register_reg);
    ev.underflow = ea_valid && (access_now.address < `SFR_TOP);
    ev.push_done = ea_valid && access_now.is_push;
  end

  // Stack pointer; also loadable and readable as a plain working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_pointer_register_reg <= `SP_RESET;
    end else if (wr_fire && aw_addr_reg == `OFS_STACK_POINTER) begin
      stack_pointer_register_reg <= {w_data_reg[15:1], 1'b0};
    end else if (op_now == OP_LOAD_SP) begin
      stack_pointer_register_reg <= {operand_reg[15:1], 1'b0};
    end else if (access_now.is_push) begin
      stack_pointer_register_reg <= stack_pointer_register_reg + 16'h0002;
    end else if (op_now == OP_POP_WORD) begin
      stack_pointer_register_reg <= effective_address;
    end
  end

  // Limit has no reset on purpose; bit zero is never stored as one
  always_ff @(posedge aclk) begin
    if (wr_fire && aw_addr_reg == `OFS_STACK_LIMIT) begin
      stack_limit_register_reg <= {w_data_reg[15:1], 1'b0};
    end
  end

  // Operand and last effective address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_reg   <= 16'h0000;
      last_addr_reg <= 16'h0000;
    end else begin
      if (wr_fire && aw_addr_reg == `OFS_OPERAND) begin
        operand_reg <= w_data_reg[15:0];
      end
      if (ea_valid) begin
        last_addr_reg <= effective_address;
      end
    end
  end

  // Stack word storage; pop and read results land in read_data_reg
  // Only low address bits index the array, so a stack deeper than it wraps onto itself
  always_ff @(posedge aclk) begin
    if (access_now.is_push) begin
      stack_mem[effective_address[AW:1]] <= push_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_data_reg <= 16'h0000;
    end else if (op_now == OP_POP_WORD || op_now == OP_READ_AT_SP) begin
      read_data_reg <= stack_mem[effective_address[AW:1]];
    end
  end

  // Sticky events; a new event wins over a same-cycle write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= (status_reg & ~((wr_fire && aw_addr_reg == `OFS_STATUS && w_strb_reg[0])
                    ? w_data_reg[2:0] : 3'h0)) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= `MASK_RESET;
    end else if (wr_fire && aw_addr_reg == `OFS_MASK && w_strb_reg[0]) begin
      mask_reg <= w_data_reg[2:0];
    end
  end

  // Interrupt level, registered so the output comes from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // Read channel; the address is taken and answered one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (s_axi_araddr == `OFS_STACK_LIMIT) begin
          s_axi_rdata <= {16'h0000, stack_limit_register_reg};
        end else if (s_axi_araddr == `OFS_STACK_POINTER) begin
          s_axi_rdata <= {16'h0000, stack_pointer_register_reg};
        end else if (s_axi_araddr == `OFS_STATUS) begin
          s_axi_rdata <= {29'h0, status_reg};
        end else if (s_axi_araddr == `OFS_MASK) begin
          s_axi_rdata <= {29'h0, mask_reg};
        end else if (s_axi_araddr == `OFS_OPERAND) begin
          s_axi_rdata <= {16'h0000, operand_reg};
        end else if (s_axi_araddr == `OFS_LAST_ADDR) begin
          s_axi_rdata <= {16'h0000, last_addr_reg};
        end else if (s_axi_araddr == `OFS_STACK_DATA) begin
          s_axi_rdata <= {16'h0000, read_data_reg};
        end else if (s_axi_araddr == `OFS_OP) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks share the aclk domain and stay quiet while reset is held
  // Helper: a push issued exactly at the limit
  logic push_at_limit;
  assign push_at_limit = access_now.is_push
                         && access_now.address == stack_limit_register_reg;

  sequence s_push_at_limit;
    push_at_limit && access_now.address >= `SFR_TOP;
  endsequence

  AST_LIMIT_PUSH_NO_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    s_push_at_limit |=> !status_reg[`STAT_OVERFLOW] || $past(status_reg[`STAT_OVERFLOW]))
    else $error("push at limit raised overflow");

  AST_OVER_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (access_now.is_push && access_now.address > stack_limit_register_reg)
    |=> status_reg[`STAT_OVERFLOW])
    else $error("push past limit missed overflow");

  AST_UNDER_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (ea_valid && effective_address < `SFR_TOP) |=> status_reg[`STAT_UNDERFLOW])
    else $error("underflow not flagged");

  AST_PUSH_INC: assert property (@(posedge aclk) disable iff (!aresetn)
    access_now.is_push |=>
      stack_pointer_register_reg == $past(stack_pointer_register_reg) + 16'h0002)
    else $error("push did not advance pointer");

  AST_POP_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_now == OP_POP_WORD) |=>
      stack_pointer_register_reg == $past(stack_pointer_register_reg) - 16'h0002)
    else $error("pop did not retreat pointer");

  AST_LIMIT_ALIGNED: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(wr_fire && aw_addr_reg == `OFS_STACK_LIMIT) |-> !stack_limit_register_reg[0])
    else $error("limit bit zero set");

  AST_SP_ALIGNED: assert property (@(posedge aclk) disable iff (!aresetn)
    !stack_pointer_register_reg[0])
    else $error("stack pointer misaligned");

  AST_CALL_MSB: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_now == OP_PUSH_CALL_PC) |-> !push_word[15])
    else $error("call push top bit set");

  AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_reg[`STAT_OVERFLOW] && !(wr_fire && aw_addr_reg == `OFS_STATUS))
    |=> status_reg[`STAT_OVERFLOW][*2] or (status_reg[`STAT_OVERFLOW] ##1 1'b1))
    else $error("overflow flag dropped");

  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    |(status_reg & mask_reg) |=> irq)
    else $error("interrupt not raised");

endmodule

// File: stack_check_cfg.svh
// Offsets, field positions, reset values and limits for the stack checker.
// Assumes inclusion by the package, the single design module and the bench.
`ifndef STACK_CHECK_CFG_SVH
`define STACK_CHECK_CFG_SVH

`define OFS_STACK_LIMIT   8'h00
`define OFS_STACK_POINTER 8'h04
`define OFS_STATUS        8'h08
`define OFS_MASK          8'h0c
`define OFS_OP            8'h10
`define OFS_OPERAND       8'h14
`define OFS_LAST_ADDR     8'h18
`define OFS_STACK_DATA    8'h1c

`define STAT_OVERFLOW     0
`define STAT_UNDERFLOW    1
`define STAT_PUSH_DONE    2

`define SP_RESET          16'h0800
`define SFR_TOP           16'h0800
`define MASK_RESET        3'h0

`endif

// File: stack_check_pkg.sv
// Types shared by the stack checker and its bench.
// Assumes the configuration header sits in the same folder.
`include "stack_check_cfg.svh"

package stack_check_pkg;

  // Operations issued by software through the operation register
  typedef enum logic [2:0] {
    OP_NONE,
    OP_PUSH_WORD,
    OP_POP_WORD,
    OP_PUSH_CALL_PC,
    OP_PUSH_EXC_PC,
    OP_LOAD_SP,
    OP_READ_AT_SP
  } stack_op_type;

  // Event bits gathered into the status word
  typedef struct packed {
    logic push_done;
    logic underflow;
    logic overflow;
  } stack_events_type;

  // One stack access as seen by the address check
  typedef struct packed {
    logic [15:0] address;
    logic        is_push;
  } stack_access_type;

endpackage

// File: stack_trap_model.sv
// Trap-side partner: counts stack error trap entries seen on irq.
// Assumes one aclk domain and a level irq from the stack checker.
`timescale 1ns/1ps
module stack_trap_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       irq,
  output logic      [7:0] trap_count
);
  logic irq_seen_reg;

  // One trap entry per rising edge; a flag held high is one event only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_seen_reg <= 1'b0;
      trap_count   <= 8'h00;
    end else begin
      irq_seen_reg <= irq;
      if (irq && !irq_seen_reg) begin
        trap_count <= trap_count + 8'h01;
      end
    end
  end
endmodule

// File: stack_limit_check_tb_top.sv
// Bench for the stack checker: AXI4-Lite tasks and directed stack scenarios.
// Assumes the package, header, design and trap model are compiled alongside.
`timescale 1ns/1ps
`include "stack_check_cfg.svh"
module stack_limit_check_tb_top;
  import stack_check_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [7:0]  trap_count;
  logic [31:0] pops [3] = '{32'h0123, 32'h4123, 32'habcd};
  int          fail_count = 0, n_compared = 0, cyc = 0;

  always #10 aclk = ~aclk;

  stack_limit_check uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  stack_trap_model trap (.aclk(aclk), .aresetn(aresetn), .irq(irq), .trap_count(trap_count));

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask

  // Operand first, since the operation register launches the access
  task automatic op(input stack_op_type c, input logic [15:0] v);
    wr(`OFS_OPERAND, {16'h0, v});
    wr(`OFS_OP, {29'h0, c});
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`OFS_STACK_POINTER, 32'h0800, "sp_reset");
    rdc(`OFS_STATUS, 32'h0, "status_reset");
    rdc(`OFS_MASK, 32'h0, "mask_reset");
    wr(`OFS_STACK_LIMIT, 32'h0a03);
    rdc(`OFS_STACK_LIMIT, 32'h0a02, "limit");
    wr(`OFS_STACK_POINTER, 32'h1234);
    rdc(`OFS_STACK_POINTER, 32'h1234, "sp_general");
    wr(`OFS_STACK_POINTER, 32'h0900);
    op(OP_PUSH_WORD, 16'habcd);
    rdc(`OFS_LAST_ADDR, 32'h0900, "push_address");
    rdc(`OFS_STACK_POINTER, 32'h0902, "sp_after_push");
    op(OP_PUSH_EXC_PC, 16'h0123);
    op(OP_PUSH_CALL_PC, 16'h8123);
    rdc(`OFS_STATUS, 32'h4, "status_in_range");
    for (int i = 0; i < 3; i++) begin
      op(OP_POP_WORD, 16'h0000);
      rdc(`OFS_STACK_DATA, pops[i], "pop_data");
    end
    rdc(`OFS_STACK_POINTER, 32'h0900, "sp_after_pops");
    wr(`OFS_STACK_POINTER, 32'h0902);
    op(OP_READ_AT_SP, 16'h0000);
    rdc(`OFS_STACK_DATA, 32'h4123, "read_at_sp");
    rdc(`OFS_STACK_POINTER, 32'h0902, "sp_after_read");
    // Pointer rewritten before the pushes that follow the limit write
    wr(`OFS_STACK_LIMIT, 32'h0902);
    wr(`OFS_STACK_POINTER, 32'h0900);
    op(OP_PUSH_WORD, 16'h1111);
    op(OP_PUSH_WORD, 16'h2222);
    rdc(`OFS_STATUS, 32'h4, "push_at_limit");
    op(OP_PUSH_WORD, 16'h3333);
    rdc(`OFS_STATUS, 32'h5, "push_past_limit");
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`OFS_MASK, 32'h1);
    rdc(`OFS_STATUS, 32'h5, "status_sticky");
    chk("irq_overflow", 32'h1, {31'h0, irq});
    chk("trap_count", 32'h1, {24'h0, trap_count});
    wr(`OFS_STATUS, 32'h1);
    rdc(`OFS_STATUS, 32'h4, "status_cleared");
    chk("irq_cleared", 32'h0, {31'h0, irq});
    op(OP_LOAD_SP, 16'h0800);
    op(OP_POP_WORD, 16'h0000);
    rdc(`OFS_STATUS, 32'h6, "underflow");
    wr(`OFS_MASK, 32'h2);
    rdc(`OFS_OP, 32'h0, "op_reads_zero");
    chk("irq_underflow", 32'h1, {31'h0, irq});
    chk("trap_count", 32'h2, {24'h0, trap_count});
    wr(8'h20, 32'h1, 2'b10);
    rd(8'h20, d, 2'b10);
    stop_test();
  end
endmodule
